//--- host_port_pkg.sv
// host_port_pkg: shared constants for the host port mode selector.
// assumes a 32-bit APB register bus with byte addresses and word-aligned registers.
`default_nettype none
package host_port_pkg;
	// host interface personalities from the two-bit select pins
	typedef enum logic [1:0] {
		IF_MUX    = 2'h0, // multiplexed parallel bus
		IF_NONMUX = 2'h1, // nonmultiplexed parallel bus
		IF_SERIAL = 2'h2, // serial port
		IF_HW     = 2'h3  // hardware strap mode
	} host_if_type;

	// bus geometry
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 32;
	localparam int BUS_W     = 8;  // shared bus pins
	localparam int EXT_EV_W  = 6;  // external event inputs
	localparam int INT_EV_W  = 2;  // events raised inside this block
	localparam int CFG_W     = 9;  // width of the configuration vector

	// register byte offsets
	localparam logic [11:0] OFF_CTRL    = 12'h000;
	localparam logic [11:0] OFF_STATUS  = 12'h004;
	localparam logic [11:0] OFF_INT_EN  = 12'h008;
	localparam logic [11:0] OFF_INT_CLR = 12'h00C;
	localparam logic [11:0] OFF_PINS    = 12'h010;

	// configuration field positions (control register and config vector)
	localparam int CFG_RX_TERM = 0;
	localparam int CFG_TX_TERM = 1;
	localparam int CFG_RX_MODE = 2; // two bits
	localparam int CFG_TX_MODE = 4; // two bits
	localparam int CFG_TX_SYNC = 6;
	localparam int CFG_RX_SYNC = 7;
	localparam int CFG_JIT_CLK = 8;

	// status bit positions of internal events
	localparam int EV_MODE_CHG = 0;
	localparam int EV_TRI_RISE = 1;

	// pin status register field positions
	localparam int PINS_IF_SEL = 0; // two bits
	localparam int PINS_TRI    = 2;
	localparam int PINS_CFG    = 3; // nine bits

	// reset values
	localparam logic [CFG_W-1:0] CTRL_RST = 9'h000;

	// synchroniser input vector layout
	localparam int SYNC_W      = 14;
	localparam int SY_BUS      = 0;  // eight bits
	localparam int SY_IF_SEL   = 8;  // two bits
	localparam int SY_TRI      = 10;
	localparam int SY_JIT      = 11;
	localparam int SY_TX_MODE1 = 12;
	localparam int SY_TX_MODE2 = 13;

	// shared pin roles
	localparam int PIN_MISO     = 0;
	localparam int PIN_SCLK     = 2;
	localparam int PIN_RSM      = 2;
	localparam int PIN_TSM      = 3;
	localparam int PIN_RX_MODE0 = 4;
	localparam int PIN_RX_MODE1 = 5;
	localparam int PIN_TX_TERM_DISABLE     = 6;
	localparam int PIN_RX_TERM_DISABLE     = 7;
endpackage
`default_nettype wire

//--- sync_2ff.sv
// sync_2ff: two-flop synchroniser, one lane per bit.
// assumes every input is a level from outside the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	genvar i;
	// one independent two-stage lane per input bit
	for (i = 0; i < W; i = i + 1) begin : g_lane
		logic meta_q; // first stage, read only by the second stage
		logic hold_q; // second stage
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				meta_q <= 1'b0;
				hold_q <= 1'b0;
			end else begin
				meta_q <= async_in[i];
				hold_q <= meta_q;
			end
		end
		assign sync_out[i] = hold_q;
	end
endmodule
`default_nettype wire

//--- host_port_mode_select.sv
// host_port_mode_select: picks the host port personality from the select straps,
// routes the shared bus pins, decodes hardware straps and drives the open-drain interrupt.
// assumes pin inputs are asynchronous; port logic and event sources sit on pclk.
//
// Overview of operation
// - interrupt pin pulled low only, while flags set
// - reset pin rising edge restores register defaults
// - reset pin high floats all pins
// - select 00 mux, 01 nonmux, 10 serial, 11 hardware
// - select 01: shared pins are data bus
// - select 00: shared pins carry address and data
// - hardware mode: receive termination off when strap 1
// - hardware mode: transmit termination off when strap 1
// - hardware mode: receive mode from strap pins
// - hardware mode: transmit mode from strap pins
// - hardware mode: transmit sync function from strap
// - hardware mode: receive sync function from strap
// - serial mode: read data out on bit 0
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module host_port_mode_select #(
	parameter int EV_W = host_port_pkg::EXT_EV_W
) (
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [host_port_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [host_port_pkg::DATA_W-1:0]  pwdata,
	output logic      [host_port_pkg::DATA_W-1:0]  prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	input  wire logic [1:0]                        host_if_sel,
	input  wire logic                              reset_tristate_in,
	input  wire logic [host_port_pkg::BUS_W-1:0]   ad_i,
	output logic      [host_port_pkg::BUS_W-1:0]   ad_o,
	output logic      [host_port_pkg::BUS_W-1:0]   ad_oe,
	input  wire logic                              jitter_clk_sel0,
	output logic                                   int_n_o,
	output logic                                   int_n_oe,
	input  wire logic                              tx_mode_sel1,
	input  wire logic                              tx_mode_sel2,
	input  wire logic [host_port_pkg::BUS_W-1:0]   par_rd_data,
	input  wire logic                              par_rd_en,
	input  wire logic                              ser_miso_data,
	input  wire logic                              ser_miso_en,
	input  wire logic [EV_W-1:0]                   event_in,
	output logic      [host_port_pkg::BUS_W-1:0]   bus_in,
	output logic                                   ser_clk,
	output logic                                   mux_bus_mode,
	output logic                                   nonmux_bus_mode,
	output logic                                   serial_mode,
	output logic                                   hw_mode,
	output logic                                   float_all,
	output logic      [host_port_pkg::CFG_W-1:0]   cfg
);
	localparam int ST_W = EV_W + host_port_pkg::INT_EV_W; // status width

	// synchronised pin levels
	logic [host_port_pkg::SYNC_W-1:0] pin_raw;  // raw pin vector
	logic [host_port_pkg::SYNC_W-1:0] pin_sync; // after two flops
	logic [host_port_pkg::BUS_W-1:0]  bus_s;    // shared bus pins
	host_port_pkg::host_if_type       mode_s;   // decoded select
	logic                             tri_s;    // reset / three-state pin
	logic [host_port_pkg::CFG_W-1:0]  strap_cfg; // hardware strap vector

	assign pin_raw = {tx_mode_sel2, tx_mode_sel1, jitter_clk_sel0,
	                  reset_tristate_in, host_if_sel, ad_i};

	// bring every pin into the pclk domain
	sync_2ff #(
		.W (host_port_pkg::SYNC_W)
	) u_pin_sync (
		.clk      (pclk),
		.rst_n    (presetn),
		.async_in (pin_raw),
		.sync_out (pin_sync)
	);

	assign bus_s  = pin_sync[host_port_pkg::SY_BUS +: host_port_pkg::BUS_W];
	assign mode_s = host_port_pkg::host_if_type'(pin_sync[host_port_pkg::SY_IF_SEL +: 2]);
	assign tri_s  = pin_sync[host_port_pkg::SY_TRI];

	// strap pins laid out like the control register
	always_comb begin
		strap_cfg = '0;
		strap_cfg[host_port_pkg::CFG_RX_TERM]     = bus_s[host_port_pkg::PIN_RX_TERM_DISABLE];
		strap_cfg[host_port_pkg::CFG_TX_TERM]     = bus_s[host_port_pkg::PIN_TX_TERM_DISABLE];
		strap_cfg[host_port_pkg::CFG_RX_MODE]     = bus_s[host_port_pkg::PIN_RX_MODE0];
		strap_cfg[host_port_pkg::CFG_RX_MODE + 1] = bus_s[host_port_pkg::PIN_RX_MODE1];
		strap_cfg[host_port_pkg::CFG_TX_MODE]     = pin_sync[host_port_pkg::SY_TX_MODE1];
		strap_cfg[host_port_pkg::CFG_TX_MODE + 1] = pin_sync[host_port_pkg::SY_TX_MODE2];
		strap_cfg[host_port_pkg::CFG_TX_SYNC]     = bus_s[host_port_pkg::PIN_TSM];
		strap_cfg[host_port_pkg::CFG_RX_SYNC]     = bus_s[host_port_pkg::PIN_RSM];
		// board sets this for T1 with the listed clocks
		strap_cfg[host_port_pkg::CFG_JIT_CLK]     = pin_sync[host_port_pkg::SY_JIT];
	end

	// register file state
	logic [host_port_pkg::CFG_W-1:0] ctrl_q, ctrl_d;     // software configuration
	logic [ST_W-1:0]                 status_q, status_d; // sticky event flags
	logic [ST_W-1:0]                 en_q, en_d;         // interrupt enables
	logic                            tri_prev_q, tri_prev_d; // edge detect history
	host_port_pkg::host_if_type      mode_prev_q, mode_prev_d; // last seen mode
	logic                            primed_q, primed_d; // history valid
	logic [host_port_pkg::DATA_W-1:0] prdata_d;
	logic                            pready_d;
	logic                            pslverr_d;

	// bus and event decode
	logic            setup_ack;  // access phase, answer not yet given
	logic            done;       // transfer completes at this edge
	logic            wr_ctrl;    // control register write
	logic            wr_en;      // enable register write
	logic            wr_clr;     // clear register write
	logic            tri_rise;   // reset pin rising edge
	logic            mode_chg;   // select pins changed
	logic [ST_W-1:0] ev_vec;     // all events this cycle
	logic            hit;        // address maps to a register

	assign setup_ack = psel && penable && !pready;
	assign done      = psel && penable && pready;
	assign wr_ctrl   = done && pwrite && (paddr == host_port_pkg::OFF_CTRL);
	assign wr_en     = done && pwrite && (paddr == host_port_pkg::OFF_INT_EN);
	assign wr_clr    = done && pwrite && (paddr == host_port_pkg::OFF_INT_CLR);
	assign tri_rise  = tri_s && !tri_prev_q;
	assign mode_chg  = primed_q && (mode_s != mode_prev_q);
	assign ev_vec    = {event_in, tri_rise, mode_chg};
	assign hit       = (paddr == host_port_pkg::OFF_CTRL)   || (paddr == host_port_pkg::OFF_STATUS)
	                || (paddr == host_port_pkg::OFF_INT_EN) || (paddr == host_port_pkg::OFF_INT_CLR)
	                || (paddr == host_port_pkg::OFF_PINS);

	// next state of registers and bus answer
	always_comb begin
		ctrl_d      = ctrl_q;
		en_d        = en_q;
		status_d    = status_q;
		tri_prev_d  = tri_s;
		mode_prev_d = mode_s;
		primed_d    = 1'b1;
		prdata_d    = '0;
		pready_d    = setup_ack;
		pslverr_d   = setup_ack && !hit;
		// software writes
		if (wr_ctrl) begin
			ctrl_d = pwdata[host_port_pkg::CFG_W-1:0];
		end
		if (wr_en) begin
			en_d = pwdata[ST_W-1:0];
		end
		// clear by write of ones; new events win over the clear
		if (wr_clr) begin
			status_d = status_q & ~pwdata[ST_W-1:0];
		end
		status_d = status_d | ev_vec;
		// register set back to defaults, edge event still recorded
		if (tri_rise) begin
			ctrl_d   = host_port_pkg::CTRL_RST;
			en_d     = '0;
			status_d = ev_vec;
		end
		// read data captured in the first access cycle
		if (setup_ack && !pwrite) begin
			case (paddr)
				host_port_pkg::OFF_CTRL: begin
					prdata_d[host_port_pkg::CFG_W-1:0] = ctrl_q;
				end
				host_port_pkg::OFF_STATUS: begin
					prdata_d[ST_W-1:0] = status_q;
				end
				host_port_pkg::OFF_INT_EN: begin
					prdata_d[ST_W-1:0] = en_q;
				end
				host_port_pkg::OFF_PINS: begin
					prdata_d[host_port_pkg::PINS_IF_SEL +: 2]                  = mode_s;
					prdata_d[host_port_pkg::PINS_TRI]                          = tri_s;
					prdata_d[host_port_pkg::PINS_CFG +: host_port_pkg::CFG_W] = cfg;
				end
				default: begin
					prdata_d = '0;
				end
			endcase
		end
	end

	// register file and bus answer flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q      <= host_port_pkg::CTRL_RST;
			en_q        <= '0;
			status_q    <= '0;
			tri_prev_q  <= 1'b0;
			mode_prev_q <= host_port_pkg::IF_MUX;
			primed_q    <= 1'b0;
			prdata      <= '0;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
		end else begin
			ctrl_q      <= ctrl_d;
			en_q        <= en_d;
			status_q    <= status_d;
			tri_prev_q  <= tri_prev_d;
			mode_prev_q <= mode_prev_d;
			primed_q    <= primed_d;
			prdata      <= prdata_d;
			pready      <= pready_d;
			pslverr     <= pslverr_d;
		end
	end

	// pin side next values
	logic [host_port_pkg::BUS_W-1:0] ad_o_d, ad_oe_d, bus_in_d;
	logic [host_port_pkg::CFG_W-1:0] cfg_d;
	logic                            int_oe_d, ser_clk_d;
	logic                            is_mux, is_nonmux, is_ser, is_hw;

	assign is_mux    = (mode_s == host_port_pkg::IF_MUX);
	assign is_nonmux = (mode_s == host_port_pkg::IF_NONMUX);
	assign is_ser    = (mode_s == host_port_pkg::IF_SERIAL);
	assign is_hw     = (mode_s == host_port_pkg::IF_HW);

	// route shared pins according to the personality
	always_comb begin
		ad_o_d    = '0;
		ad_oe_d   = '0;
		bus_in_d  = '0;
		ser_clk_d = 1'b0;
		case (mode_s)
			host_port_pkg::IF_MUX: begin
				ad_o_d   = par_rd_data;
				ad_oe_d  = {host_port_pkg::BUS_W{par_rd_en}};
				bus_in_d = bus_s;
			end
			// dedicated data bus, address on own pins
			host_port_pkg::IF_NONMUX: begin
				ad_o_d   = par_rd_data;
				ad_oe_d  = {host_port_pkg::BUS_W{par_rd_en}};
				bus_in_d = bus_s;
			end
			// read data on bit 0 only
			host_port_pkg::IF_SERIAL: begin
				ad_o_d[host_port_pkg::PIN_MISO]  = ser_miso_data;
				ad_oe_d[host_port_pkg::PIN_MISO] = ser_miso_en;
				ser_clk_d = bus_s[host_port_pkg::PIN_SCLK];
			end
			// hardware mode pins are inputs only
			default: begin
				ad_oe_d = '0;
			end
		endcase
		// float every driven pin while reset pin high
		if (tri_s) begin
			ad_oe_d = '0;
		end
		// straps count only in hardware mode
		cfg_d = is_hw ? strap_cfg : ctrl_q;
		// pull low while an enabled flag stands, pin free in hardware mode
		int_oe_d = (|(status_q & en_q)) && !is_hw && !tri_s;
	end

	// pin side flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ad_o            <= '0;
			ad_oe           <= '0;
			bus_in          <= '0;
			ser_clk         <= 1'b0;
			cfg             <= host_port_pkg::CTRL_RST;
			int_n_o         <= 1'b0;
			int_n_oe        <= 1'b0;
			mux_bus_mode    <= 1'b0;
			nonmux_bus_mode <= 1'b0;
			serial_mode     <= 1'b0;
			hw_mode         <= 1'b0;
			float_all       <= 1'b0;
		end else begin
			ad_o            <= ad_o_d;
			ad_oe           <= ad_oe_d;
			bus_in          <= bus_in_d;
			ser_clk         <= ser_clk_d;
			cfg             <= cfg_d;
			// open drain: level always low, never driven high
			int_n_o         <= 1'b0;
			int_n_oe        <= int_oe_d;
			mux_bus_mode    <= is_mux;
			nonmux_bus_mode <= is_nonmux;
			serial_mode     <= is_ser;
			hw_mode         <= is_hw;
			float_all       <= tri_s;
		end
	end
endmodule
`default_nettype wire

//--- host_port_assertions.sv
// host_port_assertions: concurrent checks on the mode selector ports.
// assumes pins settle through two sync flops and one output flop (3 edges).
`timescale 1ns/1ps
`default_nettype none
module host_port_assertions (
	input wire logic                            pclk,
	input wire logic                            presetn,
	input wire logic                            psel,
	input wire logic                            penable,
	input wire logic                            pready,
	input wire logic                            pslverr,
	input wire logic [1:0]                      host_if_sel,
	input wire logic [host_port_pkg::BUS_W-1:0] ad_i,
	input wire logic [host_port_pkg::BUS_W-1:0] ad_o,
	input wire logic [host_port_pkg::BUS_W-1:0] ad_oe,
	input wire logic                            jitter_clk_sel0,
	input wire logic                            int_n_o,
	input wire logic                            int_n_oe,
	input wire logic                            tx_mode_sel1,
	input wire logic                            tx_mode_sel2,
	input wire logic [host_port_pkg::BUS_W-1:0] par_rd_data,
	input wire logic                            par_rd_en,
	input wire logic                            ser_miso_data,
	input wire logic                            ser_miso_en,
	input wire logic                            mux_bus_mode,
	input wire logic                            nonmux_bus_mode,
	input wire logic                            serial_mode,
	input wire logic                            hw_mode,
	input wire logic                            float_all,
	input wire logic [host_port_pkg::CFG_W-1:0] cfg
);
	logic [2:0] age_q; // edges since reset release, saturating
	logic [2:0] age_d; // next age
	// count up to seven, then hold
	always_comb begin
		age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
	end
	// register the age
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			age_q <= 3'h0;
		end else begin
			age_q <= age_d;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	mode_decode_a: assert property (age_q > 3'h4 |->
		{hw_mode, serial_mode, nonmux_bus_mode, mux_bus_mode} == (4'h1 << $past(host_if_sel, 3)))
		else $error("mode outputs disagree with select");
	hw_cfg_a: assert property (age_q > 3'h4 && hw_mode |-> cfg == $past({jitter_clk_sel0,
		ad_i[2], ad_i[3], tx_mode_sel2, tx_mode_sel1, ad_i[5], ad_i[4], ad_i[6], ad_i[7]}, 3))
		else $error("config not taken from straps");
	int_pin_low_a: assert property (int_n_oe |-> int_n_o == 1'b0)
		else $error("interrupt pin driven high");
	float_quiet_a: assert property (float_all && $past(float_all) |-> ad_oe == 8'h00 && !int_n_oe)
		else $error("pin driven while floating");
	hw_quiet_a: assert property (hw_mode && $past(hw_mode) |-> ad_oe == 8'h00 && !int_n_oe)
		else $error("pin driven in hardware mode");
	// mode outputs and drive outputs come from the same cycle, so compare them side by side
	par_drive_a: assert property ((mux_bus_mode || nonmux_bus_mode) && !float_all |->
		ad_oe == ($past(par_rd_en) ? 8'hFF : 8'h00) && (!$past(par_rd_en) || ad_o == $past(par_rd_data)))
		else $error("parallel read data not on bus");
	serial_out_a: assert property (serial_mode && !float_all |->
		ad_oe == {7'h00, $past(ser_miso_en)} && (!$past(ser_miso_en) || ad_o[0] == $past(ser_miso_data)))
		else $error("serial output wrong");
	apb_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	// main scenarios reached
	cover property (hw_mode && cfg != 9'h000);
	cover property (int_n_oe);
	cover property (serial_mode && ad_oe[0]);
	cover property (pready && pslverr);
endmodule
`default_nettype wire

//--- host_board_model.sv
// host_board_model: board side of the shared pins, straps and interrupt line.
// assumes the bench supplies strap levels; device drive wins over straps.
`timescale 1ns/1ps
`default_nettype none
module host_board_model (
	input  wire logic [host_port_pkg::BUS_W-1:0] ad_o,
	input  wire logic [host_port_pkg::BUS_W-1:0] ad_oe,
	input  wire logic                            int_n_o,
	input  wire logic                            int_n_oe,
	input  wire logic [host_port_pkg::BUS_W-1:0] strap_ad,
	input  wire logic                            strap_jit,
	output logic      [host_port_pkg::BUS_W-1:0] ad_i,
	output logic                                 jitter_clk_sel0
);
	// host pins
	// each shared pin shows the device drive, else the strap
	always_comb begin
		for (int k = 0; k < host_port_pkg::BUS_W; k++) begin
			ad_i[k] = ad_oe[k] ? ad_o[k] : strap_ad[k];
		end
	end
	// jitter strap
	// open-drain line: pulled low by the device, else the board strap
	assign jitter_clk_sel0 = int_n_oe ? int_n_o : strap_jit;
endmodule
`default_nettype wire

//--- host_port_mode_select_tb.sv
// host_port_mode_select_tb: table of mode rows, then apb, interrupt, drive and float cases.
// assumes a 10 MHz pclk and the board model on the pins.
`timescale 1ns/1ps
`default_nettype none
module host_port_mode_select_tb;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, er, reset_tristate_in = 1'b0, jitter_clk_sel0, int_n_o, int_n_oe;
	logic [1:0]  host_if_sel = 2'h0;
	logic [7:0]  ad_i, ad_o, ad_oe, bus_in, par_rd_data = 8'h00, strap_ad = 8'h00;
	logic        tx_mode_sel1 = 1'b0, tx_mode_sel2 = 1'b0, par_rd_en = 1'b0, strap_jit = 1'b1;
	logic        ser_miso_data = 1'b0, ser_miso_en = 1'b0, ser_clk, float_all;
	logic        mux_bus_mode, nonmux_bus_mode, serial_mode, hw_mode;
	logic [5:0]  event_in = 6'h00;
	logic [8:0]  cfg;
	int          err_count = 0, n_tests = 0;
	// one row: select, pin straps, jitter strap, {tm2,tm1}, mode one-hot, cfg
	typedef struct packed {
		logic [1:0] sel;
		logic [7:0] ad;
		logic       jit;
		logic [1:0] tm;
		logic [3:0] mode;
		logic [8:0] cfg;
	} row_type;
	row_type rows [5] = '{'{2'h3, 8'h84, 1'h0, 2'h1, 4'h8, 9'h091}, '{2'h3, 8'h78, 1'h1, 2'h2, 4'h8, 9'h16E},
		'{2'h0, 8'hFF, 1'h1, 2'h3, 4'h1, 9'h000}, '{2'h1, 8'hFF, 1'h1, 2'h3, 4'h2, 9'h000},
		'{2'h2, 8'hFF, 1'h1, 2'h3, 4'h4, 9'h000}};
	host_port_mode_select host_port_mode_select_i (.*);
	host_board_model host_board_model_i (.*);
	always #50 pclk = ~pclk;
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// verdict and end of run
	task automatic summarize();
		if (err_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer; holds the request until pready, result in rd and er
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			err_count++;
			summarize();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task automatic pulse_event();
		event_in <= 6'h01;
		tick(1);
		event_in <= 6'h00;
	endtask
	initial begin
		tick(20);
		presetn <= 1'b1;
		tick(2);
		// mode rows: decode, strap config, bus and clock routing
		foreach (rows[i]) begin
			host_if_sel <= rows[i].sel;
			strap_ad <= rows[i].ad;
			strap_jit <= rows[i].jit;
			{tx_mode_sel2, tx_mode_sel1} <= rows[i].tm;
			tick(5);
			chk({hw_mode, serial_mode, nonmux_bus_mode, mux_bus_mode}, rows[i].mode);
			chk(cfg, rows[i].cfg);
			chk(bus_in, rows[i].sel[1] ? 8'h00 : rows[i].ad);
			chk(ser_clk, rows[i].sel == 2'h2 ? rows[i].ad[2] : 1'b0);
		end
		// registers in multiplexed mode, upper pins tied low
		host_if_sel <= 2'h0;
		strap_ad <= 8'h00;
		tick(5);
		apb(1'b1, host_port_pkg::OFF_CTRL, 32'h1A5);
		apb(1'b0, host_port_pkg::OFF_CTRL, 32'h0);
		chk(rd, 32'h1A5);
		chk(cfg, 9'h1A5);
		// pin status: select 00, reset pin low, effective config in bits 11:3
		apb(1'b0, host_port_pkg::OFF_PINS, 32'h0);
		chk(rd, 32'h00000D28);
		apb(1'b0, 12'h020, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		apb(1'b0, host_port_pkg::OFF_INT_CLR, 32'h0);
		chk(rd, 32'h0);
		// interrupt raised, cleared, then masked
		apb(1'b1, host_port_pkg::OFF_INT_CLR, 32'hFF);
		apb(1'b1, host_port_pkg::OFF_INT_EN, 32'h04);
		pulse_event();
		tick(3);
		chk({int_n_oe, jitter_clk_sel0}, 2'h2);
		apb(1'b0, host_port_pkg::OFF_STATUS, 32'h0);
		chk(rd & 32'h4, 32'h4);
		apb(1'b1, host_port_pkg::OFF_INT_CLR, 32'h04);
		tick(2);
		chk(int_n_oe, 1'b0);
		apb(1'b1, host_port_pkg::OFF_INT_EN, 32'h0);
		pulse_event();
		tick(4);
		chk(int_n_oe, 1'b0);
		// parallel read drive
		par_rd_data <= 8'h5A;
		par_rd_en <= 1'b1;
		tick(2);
		chk({ad_oe, ad_o}, 16'hFF5A);
		// serial output on bit 0 only, parallel request ignored
		host_if_sel <= 2'h2;
		{ser_miso_en, ser_miso_data} <= 2'h3;
		tick(5);
		chk({ad_oe, ad_o[0]}, 9'h003);
		ser_miso_en <= 1'b0;
		// hardware mode drives nothing
		host_if_sel <= 2'h3;
		tick(5);
		chk({ad_oe, int_n_oe}, 9'h000);
		// float with a pending interrupt, then register reset on the rising edge
		host_if_sel <= 2'h0;
		tick(5);
		apb(1'b1, host_port_pkg::OFF_INT_EN, 32'h04);
		reset_tristate_in <= 1'b1;
		tick(5);
		chk({float_all, ad_oe, int_n_oe}, 10'h200);
		reset_tristate_in <= 1'b0;
		par_rd_en <= 1'b0;
		tick(5);
		apb(1'b0, host_port_pkg::OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, host_port_pkg::OFF_INT_EN, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, host_port_pkg::OFF_STATUS, 32'h0);
		chk(rd & 32'h6, 32'h2);
		summarize();
	end
endmodule
bind host_port_mode_select host_port_assertions host_port_assertions_i (.*);
`default_nettype wire
